// ===== logic/otpr_pkg.sv
// Constants shared by the security register block: map, commands, timing
`default_nettype none
package otpr_pkg;

  // Data path and register counts
  localparam int WORD_W = 16;
  localparam int OTP_REG_COUNT = 17;
  localparam int REG_WORDS = 8;
  localparam int HALF_WORDS = 4;

  // Word addresses of the security region in the identifier space
  localparam logic [8:0] REGION_FIRST = 9'h080;
  localparam logic [8:0] REGION_LAST = 9'h109;
  localparam logic [8:0] LOCK_LOW_ADDR = 9'h080;
  localparam logic [8:0] REG0_FIRST = 9'h081;
  localparam logic [8:0] REG0_UPPER_FIRST = 9'h085;
  localparam logic [8:0] REG0_LAST = 9'h088;
  localparam logic [8:0] LOCK_HIGH_ADDR = 9'h089;
  localparam logic [8:0] REGN_FIRST = 9'h08a;
  localparam int STORE_WORDS = 138;

  // Lock word shipment values: low word bit 0 is cleared at the factory
  localparam logic [15:0] LOCK_LOW_RESET = 16'hfffe;
  localparam logic [15:0] LOCK_HIGH_RESET = 16'hffff;
  localparam logic [15:0] BLANK_WORD = 16'hffff;

  // Command codes taken on the low data byte
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM_OTP = 8'hc0;

  // Status word bit positions
  localparam int ST_READY_BIT = 7;
  localparam int ST_PGM_ERR_BIT = 4;
  localparam int ST_LOCK_ERR_BIT = 1;

  // Word program time and its cycle count at the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int PGM_TIME_NS = 500;
  localparam int PGM_CYCLES = (PGM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Interface state machine, one-hot
  typedef enum logic [4:0] {
    S_ARRAY = 5'b00001,
    S_IDENT = 5'b00010,
    S_STATUS = 5'b00100,
    S_SETUP = 5'b01000,
    S_BUSY = 5'b10000
  } otpr_state_t;

endpackage
`default_nettype wire

// ===== logic/otpr_store.sv
// Flip-flop array holding the security words and the two lock words
`timescale 1ns/1ps
`default_nettype none
module otpr_store
  import otpr_pkg::*;
#(
  parameter int WORDS = STORE_WORDS,
  parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89ab_cdef // Arbitrary
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Program port
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic [7:0] rd_idx,
  output logic [15:0] rd_data,
  // Lock words for the protection check
  output logic [15:0] lock_low,
  output logic [15:0] lock_high
);

  // Refuse an array size that does not cover the region map
  if (WORDS != STORE_WORDS)
  begin : g_words_chk
    $error("otpr_store: WORDS must match the region size");
  end

  // Array positions follow the region map, so the word map has one home
  localparam int LOW_IDX = int'(LOCK_LOW_ADDR - REGION_FIRST);
  localparam int HIGH_IDX = int'(LOCK_HIGH_ADDR - REGION_FIRST);
  localparam int ID_IDX = int'(REG0_FIRST - REGION_FIRST);

  // Storage words, index 0 is the low lock word
  logic [15:0] mem_ff [WORDS];

  // Reset restores the shipment image; programming only clears bits
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_ff[i] <= BLANK_WORD;
      mem_ff[LOW_IDX] <= LOCK_LOW_RESET;
      mem_ff[HIGH_IDX] <= LOCK_HIGH_RESET;
      for (int h = 0; h < HALF_WORDS; h++)
        mem_ff[ID_IDX + h] <= FACTORY_ID[h*16 +: 16];
    end
    else if (wr_en)
      mem_ff[wr_idx] <= mem_ff[wr_idx] & wr_data;
  end

  // Read and lock taps
  assign rd_data = mem_ff[rd_idx];
  assign lock_low = mem_ff[LOW_IDX];
  assign lock_high = mem_ff[HIGH_IDX];

endmodule
`default_nettype wire

// ===== logic/otpr_access.sv
// Command interface for reading, programming and locking security words
`timescale 1ns/1ps
`default_nettype none

module otpr_access
  import otpr_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int PGM_WAIT = PGM_CYCLES,
  parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89ab_cdef // Arbitrary
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host write strobe with word address and data
  input wire logic bus_we,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  // Host read strobe and returned word
  input wire logic bus_re,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  // Device state
  output logic dev_ready,
  output logic program_error_flag,
  output logic lock_error_flag
);

  // Refuse parameter values the logic cannot serve
  if (ADDR_W < 9)
  begin : g_addr_chk
    $error("otpr_access: ADDR_W must reach the security region");
  end
  // The timer is 16 bits wide and a zero wait would wrap it to 65536 cycles
  if (PGM_WAIT < 1 || PGM_WAIT > 65535)
  begin : g_wait_chk
    $error("otpr_access: PGM_WAIT out of range");
  end

  // True when an address lies in the security region
  function automatic logic in_region(input logic [ADDR_W-1:0] a);
    in_region = (a >= ADDR_W'(REGION_FIRST)) && (a <= ADDR_W'(REGION_LAST));
  endfunction

  // Lock state of the register owning a region word
  function automatic logic is_locked(input logic [8:0] a,
                                     input logic [15:0] lw0,
                                     input logic [15:0] lw1);
    logic [8:0] rel;
    rel = a - REGN_FIRST;
    if (a == LOCK_LOW_ADDR || a == LOCK_HIGH_ADDR)
      is_locked = 1'b0; // Lock words stay programmable
    else if (a >= REG0_FIRST && a < REG0_UPPER_FIRST)
      is_locked = ~lw0[0];
    else if (a >= REG0_UPPER_FIRST && a <= REG0_LAST)
      is_locked = ~lw0[1];
    else
      is_locked = ~lw1[rel[6:3]];
  endfunction

  // Controller state
  otpr_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] pgm_addr_ff; // Address latched with the command
  logic [15:0] busy_cnt_ff; // Remaining program cycles
  logic [15:0] rdata_ff; // Returned word
  logic rvalid_ff; // Returned word strobe
  logic pgm_err_ff; // Sticky program error
  logic lock_err_ff; // Sticky lock error
  logic ready_ff; // Not programming

  // Storage taps
  logic [15:0] store_rdata;
  logic [15:0] lock_low;
  logic [15:0] lock_high;

  // Command decode in the states that take commands
  wire cmd_state = state_ff == S_ARRAY || state_ff == S_IDENT ||
                   state_ff == S_STATUS;
  wire cmd_take = bus_we && cmd_state;
  wire [7:0] cmd_code = bus_wdata[7:0];
  wire cmd_clear = cmd_take && cmd_code == CMD_CLEAR_STATUS;
  wire cmd_program = cmd_take && cmd_code == CMD_PROGRAM_OTP;

  // Data phase of a program and its checks
  wire data_take = bus_we && state_ff == S_SETUP;
  wire tgt_in_region = in_region(pgm_addr_ff);
  wire [8:0] tgt_addr9 = pgm_addr_ff[8:0];
  wire tgt_locked = tgt_in_region &&
                    is_locked(tgt_addr9, lock_low, lock_high);
  wire bad_region = data_take && !tgt_in_region;
  wire bad_lock = data_take && tgt_locked;
  wire pgm_ok = data_take && tgt_in_region && !tgt_locked;
  wire [8:0] pgm_rel = tgt_addr9 - REGION_FIRST;
  wire [7:0] pgm_idx = pgm_rel[7:0];

  // Read path index for identifier reads
  wire rd_in_region = in_region(bus_addr);
  wire [8:0] rd_rel = bus_addr[8:0] - REGION_FIRST;
  wire [7:0] rd_idx = rd_in_region ? rd_rel[7:0] : 8'h00;

  // Status word as returned in the status state
  wire [15:0] status_word = (16'(ready_ff) << ST_READY_BIT) |
                            (16'(pgm_err_ff) << ST_PGM_ERR_BIT) |
                            (16'(lock_err_ff) << ST_LOCK_ERR_BIT);

  // Word returned for a read in the present state
  wire ident_word = state_ff == S_IDENT;
  wire [15:0] id_data = rd_in_region ? store_rdata : 16'h0000;
  wire [15:0] nxt_rdata = ident_word ? id_data :
                          (state_ff == S_ARRAY) ? 16'h0000 : status_word;

  // Errors are set on the data phase and cleared by command; set wins
  wire nxt_pgm_err = bad_region || bad_lock || (pgm_err_ff && !cmd_clear);
  wire nxt_lock_err = bad_lock || (lock_err_ff && !cmd_clear);

  // Program timer reaches its last cycle
  wire busy_done = busy_cnt_ff == 16'h0001;

  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_ARRAY, S_IDENT, S_STATUS:
      begin
        if (cmd_take)
        begin
          if (cmd_code == CMD_READ_ID)
            nxt_state = S_IDENT;
          else if (cmd_code == CMD_READ_STATUS)
            nxt_state = S_STATUS;
          else if (cmd_code == CMD_READ_ARRAY)
            nxt_state = S_ARRAY;
          else if (cmd_code == CMD_PROGRAM_OTP)
            nxt_state = S_SETUP;
        end
      end
      S_SETUP:
      begin
        // A rejected word reports at once; a good one waits out the time
        if (data_take)
          nxt_state = pgm_ok ? S_BUSY : S_STATUS;
      end
      S_BUSY:
      begin
        if (busy_done)
          nxt_state = S_STATUS;
      end
      default:
        nxt_state = S_ARRAY;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_ff <= S_ARRAY;
    else
      state_ff <= nxt_state;
  end

  // Address latch on the program command
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pgm_addr_ff <= '0;
    else if (cmd_program)
      pgm_addr_ff <= bus_addr;
  end

  // Program timer, one word per operation
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      busy_cnt_ff <= 16'h0000;
    else if (pgm_ok)
      busy_cnt_ff <= 16'(PGM_WAIT);
    else if (state_ff == S_BUSY)
      busy_cnt_ff <= busy_cnt_ff - 16'h0001;
  end

  // Ready flag drops for the whole program time
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ready_ff <= 1'b1;
    else if (pgm_ok)
      ready_ff <= 1'b0;
    else if (state_ff == S_BUSY && busy_done)
      ready_ff <= 1'b1;
  end

  // Sticky error flags
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pgm_err_ff <= 1'b0;
      lock_err_ff <= 1'b0;
    end
    else
    begin
      pgm_err_ff <= nxt_pgm_err;
      lock_err_ff <= nxt_lock_err;
    end
  end

  // Read data register, one word per read strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= bus_re;
      if (bus_re)
        rdata_ff <= nxt_rdata;
    end
  end

  // Seventeen registers and two lock words in one array
  otpr_store #(
    .WORDS(STORE_WORDS),
    .FACTORY_ID(FACTORY_ID)
  ) u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(pgm_ok),
    .wr_idx(pgm_idx),
    .wr_data(bus_wdata),
    .rd_idx(rd_idx),
    .rd_data(store_rdata),
    .lock_low(lock_low),
    .lock_high(lock_high)
  );

  // Outputs straight from flip-flops
  assign bus_rdata = rdata_ff;
  assign bus_rvalid = rvalid_ff;
  assign dev_ready = ready_ff;
  assign program_error_flag = pgm_err_ff;
  assign lock_error_flag = lock_err_ff;

endmodule
`default_nettype wire

// ===== dv/otpr_asserts.sv
// Checker of read timing, busy time and error flags
`timescale 1ns/1ps
`default_nettype none
module otpr_asserts
  import otpr_pkg::*;
#(
  parameter int PGM_WAIT = PGM_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host strobes
  input wire logic bus_we,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_re,
  // Device answers
  input wire logic bus_rvalid,
  input wire logic dev_ready,
  input wire logic program_error_flag,
  input wire logic lock_error_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Command byte, split out so $past sees a plain signal
  wire [7:0] cmd_lo = bus_wdata[7:0];
  // Clear command taken on the previous edge
  sequence clr_seen;
    $past(bus_we) && ($past(cmd_lo) == CMD_CLEAR_STATUS);
  endsequence
  // Busy ends exactly after the program time
  sequence busy_done;
    ##PGM_WAIT $rose(dev_ready);
  endsequence
  rd_answer_a: assert property (bus_re |=> bus_rvalid)
    else $error("read not answered");
  rd_pulse_a: assert property (!bus_re |=> !bus_rvalid)
    else $error("stray read valid");
  busy_len_a: assert property ($fell(dev_ready) |-> busy_done)
    else $error("busy time wrong");
  busy_cause_a: assert property ($fell(dev_ready) |-> $past(bus_we))
    else $error("busy without write");
  err_sticky_a: assert property ($fell(program_error_flag) |-> clr_seen)
    else $error("error flag lost");
  lock_pair_a: assert property (lock_error_flag |-> program_error_flag)
    else $error("lock error alone");
  err_cause_a: assert property ($rose(program_error_flag) |->
    dev_ready && $past(bus_we))
    else $error("error without write");
  busy_quiet_a: assert property (!dev_ready |=> !$rose(program_error_flag))
    else $error("error while busy");
endmodule
bind otpr_access otpr_asserts #(.PGM_WAIT(PGM_WAIT)) u_otpr_asserts (
  .sys_clk(sys_clk), .rst(rst), .bus_we(bus_we), .bus_wdata(bus_wdata),
  .bus_re(bus_re), .bus_rvalid(bus_rvalid), .dev_ready(dev_ready),
  .program_error_flag(program_error_flag),
  .lock_error_flag(lock_error_flag));
`default_nettype wire

// ===== dv/otpr_host.sv
// Host model driving write and read strobes
`timescale 1ns/1ps
`default_nettype none
module otpr_host
(
  // Clock
  input wire logic sys_clk,
  // Strobes to the device
  output logic bus_we,
  output logic bus_re,
  output logic [8:0] bus_addr,
  output logic [15:0] bus_wdata,
  // Answer from the device
  input wire logic [15:0] bus_rdata,
  input wire logic bus_rvalid
);
  // Idle at time zero
  initial
  begin
    bus_we = 1'b0;
    bus_re = 1'b0;
    bus_addr = 9'h000;
    bus_wdata = 16'h0000;
  end
  // One write; released lines are inverted so stale values never match
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_we <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  // One read; the answer is taken in its single valid cycle
  task automatic rd(input logic [8:0] a, output logic [15:0] d,
    output logic v);
    @(posedge sys_clk);
    bus_re <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_re <= 1'b0;
    bus_addr <= ~a;
    @(posedge sys_clk);
    v = bus_rvalid;
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the security register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import otpr_pkg::*;
  localparam logic [63:0] FID = 64'h5a3c_96e1_0f7b_2d48; // Arbitrary value
  logic sys_clk;
  logic rst;
  wire bus_we, bus_re, bus_rvalid, dev_ready, pe, le;
  wire [8:0] bus_addr;
  wire [15:0] bus_wdata, bus_rdata;
  logic [15:0] m [0:137]; // Expected image of the region
  logic [15:0] rdv;
  logic rv;
  logic [8:0] ra; // Random target address
  logic [15:0] rw; // Random data word
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  otpr_access #(.PGM_WAIT(2), .FACTORY_ID(FID)) u_otpr_access (
    .sys_clk(sys_clk), .rst(rst), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_re(bus_re), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .dev_ready(dev_ready),
    .program_error_flag(pe), .lock_error_flag(le));
  otpr_host u_otpr_host (.sys_clk(sys_clk), .bus_we(bus_we),
    .bus_re(bus_re), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
  function automatic logic inreg(logic [8:0] a);
    return a >= REGION_FIRST && a <= REGION_LAST;
  endfunction
  // Lock state of a word, from the expected lock words
  function automatic logic locked(logic [8:0] a);
    logic [8:0] k;
    k = a - REGN_FIRST;
    if (a >= REG0_FIRST && a < REG0_UPPER_FIRST) return !m[0][0];
    if (a >= REG0_UPPER_FIRST && a <= REG0_LAST) return !m[0][1];
    if (a >= REGN_FIRST && a <= REGION_LAST) return !m[9][k[6:3]];
    return 1'b0;
  endfunction
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Identifier read; outside the region the word reads as zero
  task automatic idrd(logic [8:0] a);
    u_otpr_host.rd(a, rdv, rv);
    chk({15'h0, rv}, 16'h0001);
    chk(rdv, inreg(a) ? m[a - REGION_FIRST] : 16'h0000);
  endtask
  // Program attempt, then flags, busy time and stored word
  task automatic op(logic [8:0] a, logic [15:0] d);
    logic lk;
    logic bad;
    lk = inreg(a) && locked(a);
    bad = !inreg(a) || lk;
    u_otpr_host.wr(9'h000, {8'h00, CMD_CLEAR_STATUS});
    u_otpr_host.wr(a, {8'h00, CMD_PROGRAM_OTP});
    u_otpr_host.wr(a, d);
    if (!bad) m[a - REGION_FIRST] &= d;
    @(posedge sys_clk);
    chk({15'h0, dev_ready}, {15'h0, bad});
    repeat (2) @(posedge sys_clk);
    chk({13'h0, dev_ready, pe, le}, {13'h0, 1'b1, bad, lk});
    u_otpr_host.wr(9'h080, {8'h00, CMD_READ_ID});
    idrd(a);
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    rst = 1'b1;
    void'($urandom(57));
    foreach (m[i]) m[i] = BLANK_WORD;
    m[0] = LOCK_LOW_RESET;
    for (int i = 0; i < 4; i++) m[1 + i] = FID[16*i +: 16];
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({13'h0, dev_ready, pe, le}, 16'h0004);
    u_otpr_host.wr(9'h080, {8'h00, CMD_READ_ID});
    for (int a = 'h7f; a <= 'h10a; a++) idrd(9'(a));
    op(9'h081, 16'h0000);
    op(9'h08a, 16'hfff0);
    op(9'h08a, 16'h0fff);
    op(9'h080, 16'hfffd);
    op(9'h085, 16'h1234);
    op(9'h080, 16'hffff);
    op(9'h089, 16'hfffe);
    op(9'h08b, 16'h0000);
    op(9'h092, 16'h00ff);
    op(9'h10a, 16'h0000);
    u_otpr_host.wr(9'h000, {8'h00, CMD_READ_STATUS});
    u_otpr_host.rd(9'h000, rdv, rv);
    chk(rdv, 16'(1 << ST_READY_BIT) | 16'(1 << ST_PGM_ERR_BIT));
    u_otpr_host.wr(9'h000, {8'h00, CMD_READ_ARRAY});
    u_otpr_host.rd(9'h081, rdv, rv);
    chk(rdv, 16'h0000);
    // The host only ever clears the upper-half lock bit in the low word
    for (int i = 0; i < 40; i++)
    begin
      ra = 9'h07c + 9'($urandom % 148);
      rw = (ra == LOCK_LOW_ADDR) ? 16'hfffd : 16'($urandom);
      op(ra, rw);
    end
    for (int a = 'h80; a <= 'h109; a++) idrd(9'(a));
    final_report();
  end
endmodule
`default_nettype wire
